// ### src/frcr_config_reg.sv
// Read configuration register with command decoding and field outputs
`timescale 1ns/10ps
`default_nettype none
module frcr_config_reg #(
    parameter logic [7:0] CMD_READ_ID    = 8'h90, // Identifier-read command
    parameter logic [7:0] CMD_READ_ARRAY = 8'hff, // Back to array reads
    parameter logic [7:0] CMD_CLR_STATUS = 8'h50  // Clears sequence errors
) (
    input  wire logic        CLK,                   // Bus clock, 40 MHz
    input  wire logic        RESETN,                // Asynchronous reset, active low
    input  wire logic        WR_STB,                // Write cycle, one-cycle pulse
    input  wire logic [15:0] ADDR,                  // Address lines A[15:0]
    input  wire logic [7:0]  WR_DATA,               // Command byte on data pins
    input  wire logic        RD_STB,                // Read cycle, one-cycle pulse
    input  wire logic        ADDRESS_LATCH_STROBE_N,// Address strobe, active low
    output logic [15:0]      RD_DATA,               // Read data
    output logic             RD_VALID,              // Read data valid pulse
    output logic [1:0]       SEQ_ERR,               // Two sticky sequence error bits
    output logic [15:0]      READ_CONFIG_WORD,      // Whole configuration word
    output logic             READ_MODE_SELECT,      // One for async page reads
    output logic [2:0]       FIRST_ACCESS_LATENCY_CODE, // Effective latency code
    output logic             LATENCY_CODE_RESERVED, // Stored code is reserved
    output logic             DATA_HOLD_SELECT,      // Two-clock data cycle
    output logic             STALL_EARLY_SELECT,    // Early indicator release
    output logic             BURST_ORDER_SELECT,    // Linear burst order
    output logic             RISING_EDGE_SELECT,    // Sync logic on rising edge
    output logic             BURST_NOWRAP_SELECT,   // No wrap within length
    output logic [2:0]       BURST_LENGTH_CODE,     // Burst length code
    output logic [4:0]       BURST_WORDS,           // Words per burst, 0 continuous
    output logic             DATA_PENDING,          // Indicator, programmed level
    output logic             FIRST_DATA             // First word driven, pulse
);
    frcr_pkg::frcr_state_t state;
    frcr_pkg::frcr_state_t next_state;
    logic [15:0]           cfg;
    logic                  strobe_d;
    logic                  latch_start;
    logic                  pending;
    logic                  cfg_write;

    function automatic logic [4:0] burst_words(input logic [2:0] code);
        case (code)
            frcr_pkg::BLEN_4:  burst_words = frcr_pkg::WORDS_4;
            frcr_pkg::BLEN_8:  burst_words = frcr_pkg::WORDS_8;
            frcr_pkg::BLEN_16: burst_words = frcr_pkg::WORDS_16;
            default:           burst_words = frcr_pkg::WORDS_CONT;
        endcase
    endfunction

    function automatic logic lat_reserved(input logic [2:0] code);
        lat_reserved = (code < frcr_pkg::LAT_MIN);
    endfunction

    assign cfg_write = WR_STB && (state == frcr_pkg::FRCR_ST_SETUP);

    // Command decoder
    always_comb begin
        next_state = state;
        if (WR_STB) begin
            case (state)
                frcr_pkg::FRCR_ST_SETUP: next_state = frcr_pkg::FRCR_ST_ARRAY;
                default: begin
                    if (WR_DATA == frcr_pkg::CMD_CFG_SETUP) begin
                        next_state = frcr_pkg::FRCR_ST_SETUP;
                    end else if (WR_DATA == CMD_READ_ID) begin
                        next_state = frcr_pkg::FRCR_ST_ID;
                    end else if (WR_DATA == CMD_READ_ARRAY) begin
                        next_state = frcr_pkg::FRCR_ST_ARRAY;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= frcr_pkg::FRCR_ST_ARRAY;
        end else begin
            state <= next_state;
        end
    end

    // Configuration word
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg <= frcr_pkg::CFG_RESET;
        end else if (cfg_write && (WR_DATA == frcr_pkg::CMD_CFG_CONFIRM)) begin
            cfg <= ADDR;
        end
    end

    // Sticky sequence errors; a new error wins over a clear
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            SEQ_ERR <= frcr_pkg::SEQ_ERR_NONE;
        end else if (cfg_write && (WR_DATA != frcr_pkg::CMD_CFG_CONFIRM)) begin
            SEQ_ERR <= frcr_pkg::SEQ_ERR_BOTH;
        end else if (WR_STB && (WR_DATA == CMD_CLR_STATUS)) begin
            SEQ_ERR <= frcr_pkg::SEQ_ERR_NONE;
        end
    end

    // Identifier-space read back
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RD_DATA  <= 16'h0000;
            RD_VALID <= 1'b0;
        end else begin
            RD_VALID <= RD_STB;
            if (RD_STB) begin
                if ((state == frcr_pkg::FRCR_ST_ID) && (ADDR == frcr_pkg::ID_OFS_READ_CFG)) begin
                    RD_DATA <= cfg;
                end else begin
                    RD_DATA <= 16'h0000;
                end
            end
        end
    end

    // Field outputs
    assign READ_CONFIG_WORD          = cfg;
    assign READ_MODE_SELECT          = cfg[frcr_pkg::BIT_READ_MODE];
    assign LATENCY_CODE_RESERVED     = lat_reserved(cfg[frcr_pkg::LAT_MSB:frcr_pkg::LAT_LSB]);
    // Reserved latency codes run as the shortest supported code
    assign FIRST_ACCESS_LATENCY_CODE = LATENCY_CODE_RESERVED ? frcr_pkg::LAT_MIN
                                     : cfg[frcr_pkg::LAT_MSB:frcr_pkg::LAT_LSB];
    assign DATA_HOLD_SELECT          = cfg[frcr_pkg::BIT_DATA_HOLD];
    assign STALL_EARLY_SELECT        = cfg[frcr_pkg::BIT_STALL_EARLY];
    // Only linear order exists; the reserved value is output as stored, not forced to linear
    assign BURST_ORDER_SELECT        = cfg[frcr_pkg::BIT_BURST_ORDER];
    assign RISING_EDGE_SELECT        = cfg[frcr_pkg::BIT_CLK_EDGE];
    assign BURST_NOWRAP_SELECT       = cfg[frcr_pkg::BIT_NOWRAP];
    assign BURST_LENGTH_CODE         = cfg[frcr_pkg::BLEN_MSB:frcr_pkg::BLEN_LSB];
    assign BURST_WORDS               = burst_words(BURST_LENGTH_CODE);

    // Address latch: strobe falling, seen on the first edge with strobe low
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            strobe_d <= 1'b1;
        end else begin
            strobe_d <= ADDRESS_LATCH_STROBE_N;
        end
    end

    assign latch_start = !READ_MODE_SELECT && !ADDRESS_LATCH_STROBE_N && strobe_d;

    frcr_first_access_timer u_timer (
        .clk        (CLK),
        .reset_n    (RESETN),
        .start      (latch_start),
        .lat_code   (FIRST_ACCESS_LATENCY_CODE),
        .hold_two   (DATA_HOLD_SELECT),
        .early      (STALL_EARLY_SELECT),
        .pending    (pending),
        .first_data (FIRST_DATA)
    );

    // Async mode keeps the indicator at its deasserted level
    assign DATA_PENDING = (pending && !READ_MODE_SELECT) ~^ cfg[frcr_pkg::BIT_POLARITY];

    cfg_load_a : assert property (@(posedge CLK) disable iff (!RESETN)
        cfg_write && (WR_DATA == frcr_pkg::CMD_CFG_CONFIRM)
        |=> (READ_CONFIG_WORD == $past(ADDR)) && (SEQ_ERR == $past(SEQ_ERR)))
        else $error("confirm did not store the address");

    cfg_stable_a : assert property (@(posedge CLK) disable iff (!RESETN)
        !cfg_write |=> $stable(READ_CONFIG_WORD))
        else $error("configuration changed outside configure sequence");

    seq_error_a : assert property (@(posedge CLK) disable iff (!RESETN)
        cfg_write && (WR_DATA != frcr_pkg::CMD_CFG_CONFIRM)
        |=> (SEQ_ERR == frcr_pkg::SEQ_ERR_BOTH) && $stable(READ_CONFIG_WORD))
        else $error("bad second code did not flag both errors");

    id_read_a : assert property (@(posedge CLK) disable iff (!RESETN)
        RD_STB && (state == frcr_pkg::FRCR_ST_ID) && (ADDR == frcr_pkg::ID_OFS_READ_CFG)
        |=> RD_VALID && (RD_DATA == $past(READ_CONFIG_WORD)))
        else $error("identifier read did not return configuration word");

    async_idle_a : assert property (@(posedge CLK) disable iff (!RESETN)
        READ_MODE_SELECT |-> !latch_start && (DATA_PENDING != cfg[frcr_pkg::BIT_POLARITY]))
        else $error("indicator active in async mode");

    polarity_a : assert property (@(posedge CLK) disable iff (!RESETN)
        (pending && !READ_MODE_SELECT) |-> (DATA_PENDING == cfg[frcr_pkg::BIT_POLARITY]))
        else $error("indicator level does not follow polarity bit");

    burst_len_a : assert property (@(posedge CLK) disable iff (!RESETN)
        (BURST_LENGTH_CODE == frcr_pkg::BLEN_16) |-> (BURST_WORDS == frcr_pkg::WORDS_16))
        else $error("sixteen-word code decoded wrongly");

    latency_clamp_a : assert property (@(posedge CLK) disable iff (!RESETN)
        (FIRST_ACCESS_LATENCY_CODE >= frcr_pkg::LAT_MIN)
        && (LATENCY_CODE_RESERVED == (cfg[frcr_pkg::LAT_MSB:frcr_pkg::LAT_LSB] < frcr_pkg::LAT_MIN)))
        else $error("latency code outside supported range");

    reset_mode_a : assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(RESETN) |-> READ_MODE_SELECT && (READ_CONFIG_WORD == frcr_pkg::CFG_RESET))
        else $error("reset did not restore defaults");
endmodule : frcr_config_reg
`default_nettype wire

// ### include/frcr_pkg.sv
// Shared constants for the flash read configuration register block
package frcr_pkg;
    // Command codes seen on the low data byte of a write cycle
    localparam logic [7:0]  CMD_CFG_SETUP   = 8'h60;
    localparam logic [7:0]  CMD_CFG_CONFIRM = 8'h03;

    // Identifier-space word that returns the configuration word
    localparam logic [15:0] ID_OFS_READ_CFG = 16'h0005;

    // Field positions of the configuration word
    localparam int          BIT_READ_MODE   = 15;
    localparam int          BIT_RSVD_HI     = 14;
    localparam int          LAT_MSB         = 13;
    localparam int          LAT_LSB         = 11;
    localparam int          BIT_POLARITY    = 10;
    localparam int          BIT_DATA_HOLD   = 9;
    localparam int          BIT_STALL_EARLY = 8;
    localparam int          BIT_BURST_ORDER = 7;
    localparam int          BIT_CLK_EDGE    = 6;
    localparam int          RSVD_LO_MSB     = 5;
    localparam int          RSVD_LO_LSB     = 4;
    localparam int          BIT_NOWRAP      = 3;
    localparam int          BLEN_MSB        = 2;
    localparam int          BLEN_LSB        = 0;

    // Defaults: async page mode, code 7, active high, two-clock hold,
    // early release, linear, rising edge, no wrap, continuous
    localparam logic [15:0] CFG_RESET       = 16'hbfcf;

    // Latency code encodings
    localparam logic [2:0]  LAT_MIN         = 3'h2;
    localparam logic [2:0]  LAT_MAX         = 3'h7;

    // Burst length encodings and word counts (zero means continuous)
    localparam logic [2:0]  BLEN_4          = 3'h1;
    localparam logic [2:0]  BLEN_8          = 3'h2;
    localparam logic [2:0]  BLEN_16         = 3'h3;
    localparam logic [2:0]  BLEN_CONT       = 3'h7;
    localparam logic [4:0]  WORDS_4         = 5'h04;
    localparam logic [4:0]  WORDS_8         = 5'h08;
    localparam logic [4:0]  WORDS_16        = 5'h10;
    localparam logic [4:0]  WORDS_CONT      = 5'h00;

    // Length of one data cycle in clocks
    localparam logic [2:0]  HOLD_ONE        = 3'h1;
    localparam logic [2:0]  HOLD_TWO        = 3'h2;

    localparam logic [1:0]  SEQ_ERR_BOTH    = 2'h3;
    localparam logic [1:0]  SEQ_ERR_NONE    = 2'h0;

    // Command decoder states
    typedef enum logic [2:0] {
        FRCR_ST_ARRAY = 3'b001,
        FRCR_ST_ID    = 3'b010,
        FRCR_ST_SETUP = 3'b100
    } frcr_state_t;
endpackage : frcr_pkg

// ### src/frcr_first_access_timer.sv
// First-access latency counter and data-pending indicator timing
`timescale 1ns/10ps
`default_nettype none
module frcr_first_access_timer (
    input  wire logic       clk,        // Bus clock
    input  wire logic       reset_n,    // Asynchronous reset, active low
    input  wire logic       start,      // Address latched, sync mode
    input  wire logic [2:0] lat_code,   // Effective latency code
    input  wire logic       hold_two,   // Two-clock data cycle
    input  wire logic       early,      // Release one data cycle early
    output logic            pending,    // Data-pending, logical level
    output logic            first_data  // First word driven this cycle
);
    logic       busy;
    logic [2:0] cnt;
    logic [2:0] hold_len;

    assign hold_len = hold_two ? frcr_pkg::HOLD_TWO : frcr_pkg::HOLD_ONE;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            cnt  <= 3'h0;
        end else if (start) begin
            busy <= 1'b1;
            cnt  <= lat_code - 3'h1;
        end else if (busy) begin
            cnt  <= cnt - 3'h1;
            busy <= (cnt != 3'h1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            first_data <= 1'b0;
        end else begin
            first_data <= busy && !start && (cnt == 3'h1);
        end
    end

    // Early release drops the indicator one data cycle ahead of data
    assign pending = busy && !(early && (cnt <= hold_len));

    first_word_a : assert property (@(posedge clk) disable iff (!reset_n)
        start && (lat_code == 3'h3) |-> !first_data ##3 first_data)
        else $error("first word not after three clocks for code 3");

    late_release_a : assert property (@(posedge clk) disable iff (!reset_n)
        start && (lat_code == 3'h4) && !early |=> pending [*3] ##1 !pending)
        else $error("indicator not released with valid data");

    early_release_a : assert property (@(posedge clk) disable iff (!reset_n)
        start && (lat_code == 3'h4) && early && !hold_two
        |=> pending [*2] ##1 (!pending && !first_data) ##1 first_data)
        else $error("indicator not released one cycle before data");
endmodule : frcr_first_access_timer
`default_nettype wire

// ### sim/frcr_host_model.sv
// Host-side model that drives command, read and address strobe cycles
`timescale 1ns/10ps
`default_nettype none
module frcr_host_model #(
    parameter logic [7:0] ID_CMD = 8'h90  // Identifier-read command
) (
    input  wire logic   clk,      // Bus clock
    output logic        wr_stb,   // Write cycle
    output logic [15:0] addr,     // Address lines
    output logic [7:0]  wr_data,  // Command byte
    output logic        rd_stb,   // Read cycle
    output logic        latch_n   // Address strobe
);
    initial begin
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 16'h0000;
        wr_data = 8'h00;
        latch_n = 1'b1;
    end
    // Released lines show the inverse, so a stale value is never taken as live
    task automatic put(input logic [7:0] d, input logic [15:0] a);
        @(negedge clk);
        wr_stb = 1'b1;
        wr_data = d;
        addr = a;
        @(negedge clk);
        wr_stb = 1'b0;
        wr_data = ~d;
        addr = ~a;
    endtask
    task automatic get(input logic [15:0] a);
        @(negedge clk);
        rd_stb = 1'b1;
        addr = a;
        @(negedge clk);
        rd_stb = 1'b0;
        addr = ~a;
    endtask
    task automatic configure(input logic [15:0] w);
        put(frcr_pkg::CMD_CFG_SETUP, 16'h0000);
        put(frcr_pkg::CMD_CFG_CONFIRM, w);
        put(ID_CMD, 16'h0000);
    endtask
    task automatic pulse_latch;
        @(negedge clk);
        latch_n = 1'b0;
        @(negedge clk);
        latch_n = 1'b1;
    endtask
endmodule // frcr_host_model
`default_nettype wire

// ### sim/test_flash_read_config_register.sv
// Self-checking bench for the read configuration register
`timescale 1ns/10ps
`default_nettype none
module test_flash_read_config_register;
    logic clk, resetn, wr_stb, rd_stb, latch_n, rd_valid, lcr, rms, dhs, ses, bos, res, bns;
    logic pend, first;
    logic [15:0] addr, rd_data, cfg, w;
    logic [7:0]  wr_data;
    logic [1:0]  seq_err;
    logic [2:0]  falc, blc;
    logic [4:0]  bwords;
    logic [15:0] exp_q[$];
    int n_fail = 0, n_checks = 0, cyc = 0, fd_at, pn, lc;
    integer seed = 32'h39192a37;

    frcr_host_model u_frcr_host_model (.clk(clk), .wr_stb(wr_stb), .addr(addr),
        .wr_data(wr_data), .rd_stb(rd_stb), .latch_n(latch_n));
    frcr_config_reg u_frcr_config_reg (.CLK(clk), .RESETN(resetn), .WR_STB(wr_stb),
        .ADDR(addr), .WR_DATA(wr_data), .RD_STB(rd_stb), .ADDRESS_LATCH_STROBE_N(latch_n),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .SEQ_ERR(seq_err), .READ_CONFIG_WORD(cfg),
        .READ_MODE_SELECT(rms), .FIRST_ACCESS_LATENCY_CODE(falc),
        .LATENCY_CODE_RESERVED(lcr), .DATA_HOLD_SELECT(dhs), .STALL_EARLY_SELECT(ses),
        .BURST_ORDER_SELECT(bos), .RISING_EDGE_SELECT(res), .BURST_NOWRAP_SELECT(bns),
        .BURST_LENGTH_CODE(blc), .BURST_WORDS(bwords), .DATA_PENDING(pend),
        .FIRST_DATA(first));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t word got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_count(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            n_fail++;
            $display("FAIL %0t count got %0d expected %0d", $time, got, exp);
        end
    endtask
    // Reads are noted first, then the monitor matches them as data returns
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        u_frcr_host_model.get(a);
    endtask
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk_word(rd_data, 16'hxxxx);
            else
                chk_word(rd_data, exp_q.pop_front());
        end
    end
    function automatic logic [4:0] words(input logic [2:0] c);
        case (c)
            3'h1: return 5'h04;
            3'h2: return 5'h08;
            3'h3: return 5'h10;
            default: return 5'h00;
        endcase
    endfunction
    task automatic fields(input logic [15:0] v);
        logic       rsv;
        logic [2:0] lat;
        // Reserved latency codes are flagged and run as the shortest code
        rsv = (v[13:11] < 3'h2);
        lat = rsv ? 3'h2 : v[13:11];
        chk_word(cfg, v);
        chk_word({3'h0, lcr, rms, falc, dhs, ses, bos, res, bns, blc},
            {3'h0, rsv, v[15], lat, v[9], v[8], v[7], v[6], v[3], v[2:0]});
        chk_word({11'h0, bwords}, {11'h0, words(v[2:0])});
        // Idle indicator sits at its deasserted level
        chk_word({15'h0, pend}, {15'h0, ~v[10]});
    endtask
    task automatic reset_check;
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        fields(16'hbfcf);
        chk_word({14'h0, seq_err}, 16'h0000);
        chk_word({15'h0, pend}, 16'h0000);
        rd(16'h0005, 16'h0000);
        u_frcr_host_model.put(8'h90, 16'h0000);
        rd(16'h0005, 16'hbfcf);
        rd(16'h0006, 16'h0000);
        $display("reset defaults test done");
    endtask
    initial begin
        resetn = 1'b0;
        reset_check();
        for (int i = 0; i < 8; i++) begin
            w = 16'($random(seed));
            w[14] = 1'b0;
            w[5:4] = 2'b00;
            if (w[13:11] <= 3'h2 && w[9] && w[8]) w[8] = 1'b0;
            u_frcr_host_model.configure(w);
            fields(w);
            rd(16'h0005, w);
        end
        $display("random configuration test done");
        u_frcr_host_model.put(8'h60, 16'h0000);
        rd(16'h0005, 16'h0000);
        u_frcr_host_model.put(8'h03, 16'h1bcf);
        fields(16'h1bcf);
        u_frcr_host_model.put(8'h60, 16'h0000);
        u_frcr_host_model.put(8'h01, 16'hbfcf);
        chk_word({14'h0, seq_err}, 16'h0003);
        fields(16'h1bcf);
        u_frcr_host_model.put(8'h50, 16'h0000);
        chk_word({14'h0, seq_err}, 16'h0000);
        u_frcr_host_model.put(8'h90, 16'h0000);
        rd(16'h0005, 16'h1bcf);
        u_frcr_host_model.put(8'hff, 16'h0000);
        rd(16'h0005, 16'h0000);
        $display("command sequence test done");
        // Codes 2..7, then codes 3 and 4 again so both release styles are seen
        for (int l = 2; l < 10; l++) begin
            lc = (l > 7) ? l - 5 : l;
            w = 16'($random(seed));
            w = {2'b00, 3'(lc), w[10:8], 2'b11, 2'b00, 4'b1111};
            if (l == 4) w[9:8] = 2'b01;
            if (l == 9) w[8] = 1'b0;
            if (lc == 2 && w[9] && w[8]) w[8] = 1'b0;
            u_frcr_host_model.configure(w);
            fd_at = 0;
            pn = 0;
            u_frcr_host_model.pulse_latch();
            // Sample n shows what the design holds after the n-th edge past the latch
            for (int n = 1; n < 13; n++) begin
                if (first === 1'b1 && fd_at == 0) fd_at = n;
                if (pend === w[10]) pn++;
                @(negedge clk);
            end
            chk_count(fd_at, lc);
            chk_count(pn, w[8] ? ((lc - (w[9] ? 2 : 1)) > 1 ? lc - (w[9] ? 2 : 1) - 1 : 0)
                : lc - 1);
        end
        $display("first access timing test done");
        reset_check();
        repeat (3) @(negedge clk);
        chk_count(exp_q.size(), 0);
        wrap_up();
    end
endmodule // test_flash_read_config_register
`default_nettype wire
